// ==== hdl/gpio_pkg.sv ====
// Shared constants and bus carriers for the three-port pin logic
package gpio_pkg;
	localparam int ADDR_W = 8;
	localparam int IDX_W = ADDR_W - 2;
	localparam int DATA_W = 32;
	localparam int PORT_A_W = 8;
	localparam int PORT_B_W = 8;
	localparam int PORT_C_W = 7;
	localparam int ADC_CH_W = 5;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_LATCH_A = 6'h00;
	localparam logic [IDX_W-1:0] IDX_LATCH_B = 6'h01;
	localparam logic [IDX_W-1:0] IDX_LATCH_C = 6'h02;
	localparam logic [IDX_W-1:0] IDX_DIR_A   = 6'h04;
	localparam logic [IDX_W-1:0] IDX_DIR_B   = 6'h05;
	localparam logic [IDX_W-1:0] IDX_DIR_C   = 6'h06;
	localparam logic [IDX_W-1:0] IDX_PULL_A  = 6'h0D;
	localparam logic [IDX_W-1:0] IDX_PULL_C  = 6'h0E;
	localparam logic [IDX_W-1:0] IDX_KEYPAD  = 6'h10;
	localparam logic [IDX_W-1:0] IDX_ROUTE   = 6'h11;

	// Routing register fields
	localparam int ROUTE_CAN_EN_BIT = 0;
	localparam int ROUTE_ADC_EN_BIT = 1;
	localparam int ROUTE_ADC_CH_LSB = 2;

	// Values after reset
	localparam logic [7:0] DIR_RESET    = 8'h00;
	localparam logic [7:0] PULL_RESET   = 8'h00;
	localparam logic [7:0] KEYPAD_RESET = 8'h00;
	localparam logic [4:0] ADC_CH_RESET = 5'h00;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} axil_rsp_t;
endpackage

// ==== hdl/gpio_ports_abc.sv ====
// Pin logic for two 8-bit ports and one 7-bit port behind an AXI4-Lite slave
//
// Summary of operation
// - Direction bit 1 enables the pin driver; 0 makes the pin an input.
// - Reset clears every direction bit so all pins start as inputs.
// - Reset leaves the second and third port data latches untouched.
// - Data reads return the latch for output pins; ports at indices 0, 1, 2.
// - Data reads return the sampled pin level for input pins.
// - Data writes with wstrb bit 0 set update the latches, whatever the direction.
// - Writing an input pin's latch changes neither pin nor readback.
// - Pullup enable 1 connects the pullup on first and third ports; 0 disconnects.
// - Pullup acts only while direction is input; output disables it at once.
// - A converter channel select on a second-port pin takes that pin over.
// - CAN enable turns the two lowest third-port pins into CAN pins.
// - Third port has seven pins, bits 6 to 0; the others have eight.
// - Second port has no pullups; its input pins float.
// - Reset leaves the first port's data latch untouched.
// - Keypad enable bits turn first-port pins into interrupt inputs.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_abc (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	// Register bus
	input  wire gpio_pkg::axil_req_t         bus_req,
	output gpio_pkg::axil_rsp_t              bus_rsp,
	// First port pins
	input  wire logic [gpio_pkg::PORT_A_W-1:0] a_pin_in,
	output logic      [gpio_pkg::PORT_A_W-1:0] a_pin_out,
	output logic      [gpio_pkg::PORT_A_W-1:0] a_pin_oe,
	output logic      [gpio_pkg::PORT_A_W-1:0] a_pullup_on,
	// Second port pins
	input  wire logic [gpio_pkg::PORT_B_W-1:0] b_pin_in,
	output logic      [gpio_pkg::PORT_B_W-1:0] b_pin_out,
	output logic      [gpio_pkg::PORT_B_W-1:0] b_pin_oe,
	output logic      [gpio_pkg::PORT_B_W-1:0] analog_channel_pins,
	// Third port pins
	input  wire logic [gpio_pkg::PORT_C_W-1:0] c_pin_in,
	output logic      [gpio_pkg::PORT_C_W-1:0] c_pin_out,
	output logic      [gpio_pkg::PORT_C_W-1:0] c_pin_oe,
	output logic      [gpio_pkg::PORT_C_W-1:0] c_pullup_on,
	// CAN controller side
	input  wire logic                        can_transmit_pin,
	output logic                             can_receive_pin,
	// Keypad interrupt side
	output logic      [gpio_pkg::PORT_A_W-1:0] keypad_inputs
);
	import gpio_pkg::*;

	localparam int SYNC_W = PORT_A_W + PORT_B_W + PORT_C_W;

	typedef struct packed {
		logic [PORT_A_W-1:0] dir_a;
		logic [PORT_B_W-1:0] dir_b;
		logic [PORT_C_W-1:0] dir_c;
		logic [PORT_A_W-1:0] pull_a;
		logic [PORT_C_W-1:0] pull_c;
		logic [PORT_A_W-1:0] keypad_en;
		logic                can_en;
		logic                adc_en;
		logic [ADC_CH_W-1:0] adc_ch;
		logic                aw_held;
		logic [IDX_W-1:0]    aw_idx;
		logic                w_held;
		logic [7:0]          w_byte;
		logic                w_lane0;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [DATA_W-1:0]   rdata;
		logic [1:0]          rresp;
		logic [PORT_A_W-1:0] a_out;
		logic [PORT_A_W-1:0] a_oe;
		logic [PORT_A_W-1:0] a_pull;
		logic [PORT_B_W-1:0] b_out;
		logic [PORT_B_W-1:0] b_oe;
		logic [PORT_B_W-1:0] analog_sel;
		logic [PORT_C_W-1:0] c_out;
		logic [PORT_C_W-1:0] c_oe;
		logic [PORT_C_W-1:0] c_pull;
		logic                can_rx;
		logic [PORT_A_W-1:0] keypad_out;
	} ctrl_state_t;

	typedef struct packed {
		logic [PORT_A_W-1:0] a;
		logic [PORT_B_W-1:0] b;
		logic [PORT_C_W-1:0] c;
	} latch_state_t;

	ctrl_state_t  cur;
	ctrl_state_t  next_cur;
	latch_state_t latch;
	latch_state_t next_latch;

	logic [SYNC_W-1:0]   pins_sync;
	logic [PORT_A_W-1:0] a_sync;
	logic [PORT_B_W-1:0] b_sync;
	logic [PORT_C_W-1:0] c_sync;
	logic                aw_ready;
	logic                w_ready;
	logic                ar_ready;

	// Word index of a byte address; low two bits ignored
	function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
		return addr[ADDR_W-1:2];
	endfunction

	// Latch for driven pins, pin level for inputs
	function automatic logic [7:0] port_view(
		input logic [7:0] lat,
		input logic [7:0] dir,
		input logic [7:0] pins
	);
		return (dir & lat) | (~dir & pins);
	endfunction

	pin_sync #(
		.W (SYNC_W)
	) u_pin_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in ({a_pin_in, b_pin_in, c_pin_in}),
		.sync_out (pins_sync)
	);

	assign a_sync = pins_sync[SYNC_W-1 -: PORT_A_W];
	assign b_sync = pins_sync[PORT_C_W +: PORT_B_W];
	assign c_sync = pins_sync[PORT_C_W-1:0];

	// Ready only while the slot is empty, so a held item is never overwritten
	assign aw_ready = !cur.aw_held;
	assign w_ready = !cur.w_held;
	assign ar_ready = !cur.rvalid;

	always_comb
	begin
		next_cur = cur;
		next_latch = latch;

		if (bus_req.awvalid && aw_ready)
		begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_idx = word_index(bus_req.awaddr);
		end
		if (bus_req.wvalid && w_ready)
		begin
			next_cur.w_held = 1'b1;
			next_cur.w_byte = bus_req.wdata[7:0];
			next_cur.w_lane0 = bus_req.wstrb[0];
		end
		if (cur.bvalid && bus_req.bready)
			next_cur.bvalid = 1'b0;

		// Write commits once address and data are both in and no response is pending
		if (cur.aw_held && cur.w_held && !cur.bvalid)
		begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = RESP_OKAY;
			case (cur.aw_idx)
				IDX_LATCH_A:
				begin
					if (cur.w_lane0)
						next_latch.a = cur.w_byte;
				end
				IDX_LATCH_B:
				begin
					if (cur.w_lane0)
						next_latch.b = cur.w_byte;
				end
				IDX_LATCH_C:
				begin
					if (cur.w_lane0)
						next_latch.c = cur.w_byte[PORT_C_W-1:0];
				end
				IDX_DIR_A:
				begin
					if (cur.w_lane0)
						next_cur.dir_a = cur.w_byte;
				end
				IDX_DIR_B:
				begin
					if (cur.w_lane0)
						next_cur.dir_b = cur.w_byte;
				end
				IDX_DIR_C:
				begin
					if (cur.w_lane0)
						next_cur.dir_c = cur.w_byte[PORT_C_W-1:0];
				end
				IDX_PULL_A:
				begin
					if (cur.w_lane0)
						next_cur.pull_a = cur.w_byte;
				end
				IDX_PULL_C:
				begin
					if (cur.w_lane0)
						next_cur.pull_c = cur.w_byte[PORT_C_W-1:0];
				end
				IDX_KEYPAD:
				begin
					if (cur.w_lane0)
						next_cur.keypad_en = cur.w_byte;
				end
				IDX_ROUTE:
				begin
					if (cur.w_lane0)
					begin
						next_cur.can_en = cur.w_byte[ROUTE_CAN_EN_BIT];
						next_cur.adc_en = cur.w_byte[ROUTE_ADC_EN_BIT];
						next_cur.adc_ch = cur.w_byte[ROUTE_ADC_CH_LSB +: ADC_CH_W];
					end
				end
				default:
					next_cur.bresp = RESP_SLVERR;
			endcase
		end

		if (cur.rvalid && bus_req.rready)
			next_cur.rvalid = 1'b0;

		// Pin levels read here are already two flops old
		if (bus_req.arvalid && ar_ready)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = RESP_OKAY;
			next_cur.rdata = '0;
			case (word_index(bus_req.araddr))
				IDX_LATCH_A:
					next_cur.rdata[7:0] = port_view(latch.a, cur.dir_a, a_sync);
				IDX_LATCH_B:
					next_cur.rdata[7:0] = port_view(latch.b, cur.dir_b, b_sync);
				IDX_LATCH_C:
					next_cur.rdata[7:0] = port_view({1'b0, latch.c}, {1'b0, cur.dir_c},
						{1'b0, c_sync});
				IDX_DIR_A:
					next_cur.rdata[7:0] = cur.dir_a;
				IDX_DIR_B:
					next_cur.rdata[7:0] = cur.dir_b;
				IDX_DIR_C:
					next_cur.rdata[7:0] = {1'b0, cur.dir_c};
				IDX_PULL_A:
					next_cur.rdata[7:0] = cur.pull_a;
				IDX_PULL_C:
					next_cur.rdata[7:0] = {1'b0, cur.pull_c};
				IDX_KEYPAD:
					next_cur.rdata[7:0] = cur.keypad_en;
				IDX_ROUTE:
				begin
					next_cur.rdata[ROUTE_CAN_EN_BIT] = cur.can_en;
					next_cur.rdata[ROUTE_ADC_EN_BIT] = cur.adc_en;
					next_cur.rdata[ROUTE_ADC_CH_LSB +: ADC_CH_W] = cur.adc_ch;
				end
				default:
					next_cur.rresp = RESP_SLVERR;
			endcase
		end

		// First port: keypad-enabled pins are held as inputs
		next_cur.a_out = latch.a;
		next_cur.a_oe = cur.dir_a & ~cur.keypad_en;
		next_cur.a_pull = cur.pull_a & ~cur.dir_a;
		next_cur.keypad_out = a_sync & cur.keypad_en;

		// Second port: a selected converter channel wins over direction
		next_cur.analog_sel = '0;
		if (cur.adc_en && (cur.adc_ch < ADC_CH_W'(PORT_B_W)))
			next_cur.analog_sel = 8'(8'h01 << cur.adc_ch[2:0]);
		next_cur.b_out = latch.b;
		next_cur.b_oe = cur.dir_b & ~next_cur.analog_sel;

		// Third port, with the two lowest pins lent to CAN when enabled
		next_cur.c_out = latch.c;
		next_cur.c_oe = cur.dir_c;
		next_cur.c_pull = cur.pull_c & ~cur.dir_c;
		// Recessive level while the CAN pins stay general-purpose
		next_cur.can_rx = 1'b1;
		if (cur.can_en)
		begin
			next_cur.c_out[0] = can_transmit_pin;
			next_cur.c_oe[0] = 1'b1;
			next_cur.c_pull[0] = 1'b0;
			next_cur.c_oe[1] = 1'b0;
			next_cur.c_pull[1] = 1'b0;
			next_cur.can_rx = c_sync[1];
		end
	end

	// Control state resets; idle CAN receive reads recessive high
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cur <= '0;
			cur.dir_a <= DIR_RESET;
			cur.dir_b <= DIR_RESET;
			cur.dir_c <= DIR_RESET[PORT_C_W-1:0];
			cur.pull_a <= PULL_RESET;
			cur.pull_c <= PULL_RESET[PORT_C_W-1:0];
			cur.keypad_en <= KEYPAD_RESET;
			cur.adc_ch <= ADC_CH_RESET;
			cur.can_rx <= 1'b1;
		end
		else
			cur <= next_cur;
	end

	// Data latches have no reset: contents survive a reset
	// Unknown until first written, so load them before driving a pin
	always_ff @(posedge clock)
	begin
		latch <= next_latch;
	end

	assign bus_rsp.awready = aw_ready;
	assign bus_rsp.wready = w_ready;
	assign bus_rsp.bresp = cur.bresp;
	assign bus_rsp.bvalid = cur.bvalid;
	assign bus_rsp.arready = ar_ready;
	assign bus_rsp.rdata = cur.rdata;
	assign bus_rsp.rresp = cur.rresp;
	assign bus_rsp.rvalid = cur.rvalid;

	assign a_pin_out = cur.a_out;
	assign a_pin_oe = cur.a_oe;
	assign a_pullup_on = cur.a_pull;
	assign b_pin_out = cur.b_out;
	assign b_pin_oe = cur.b_oe;
	assign analog_channel_pins = cur.analog_sel;
	assign c_pin_out = cur.c_out;
	assign c_pin_oe = cur.c_oe;
	assign c_pullup_on = cur.c_pull;
	assign can_receive_pin = cur.can_rx;
	assign keypad_inputs = cur.keypad_out;
endmodule
`default_nettype wire

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset_n,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_state_t;

	sync_state_t cur;
	sync_state_t next_cur;

	// First stage feeds only the second stage
	always_comb
	begin
		next_cur.first = async_in;
		next_cur.second = cur.first;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign sync_out = cur.second;
endmodule
`default_nettype wire

// ==== verif/gpio_ports_abc_sva.sv ====
// Concurrent checks on the three-port pin block
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_abc_sva
	import gpio_pkg::*;
(
	// Clock and reset
	input wire logic                            clock,
	input wire logic                            reset_n,
	// Register bus
	input wire gpio_pkg::axil_req_t             bus_req,
	input wire gpio_pkg::axil_rsp_t             bus_rsp,
	// Pin controls
	input wire logic [gpio_pkg::PORT_A_W-1:0]   a_pin_oe,
	input wire logic [gpio_pkg::PORT_A_W-1:0]   a_pullup_on,
	input wire logic [gpio_pkg::PORT_B_W-1:0]   b_pin_oe,
	input wire logic [gpio_pkg::PORT_B_W-1:0]   analog_channel_pins,
	input wire logic [gpio_pkg::PORT_C_W-1:0]   c_pin_oe,
	input wire logic [gpio_pkg::PORT_C_W-1:0]   c_pullup_on
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_pull_a; (a_pullup_on & a_pin_oe) == '0; endproperty
	a_pull_a: assert property (p_pull_a) else $error("pullup on driven pin");
	property p_pull_c; (c_pullup_on & c_pin_oe) == '0; endproperty
	a_pull_c: assert property (p_pull_c) else $error("pullup on driven pin");
	property p_adc_oe; (analog_channel_pins & b_pin_oe) == '0; endproperty
	a_adc_oe: assert property (p_adc_oe) else $error("converter pin driven");
	property p_adc_one; $onehot0(analog_channel_pins); endproperty
	a_adc_one: assert property (p_adc_one) else $error("two converter pins");
	property p_rst; $rose(reset_n) |-> {a_pin_oe, b_pin_oe, c_pin_oe} == '0; endproperty
	a_rst: assert property (p_rst) else $error("driver on after reset");
	property p_wr; bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready
		&& !bus_rsp.bvalid |-> ##2 bus_rsp.bvalid; endproperty
	a_wr: assert property (p_wr) else $error("late write response");
	property p_rd; bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid; endproperty
	a_rd: assert property (p_rd) else $error("late read response");
	property p_bdone; bus_rsp.bvalid && bus_req.bready |=> !bus_rsp.bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write response repeated");
	property p_rdone; bus_rsp.rvalid && bus_req.rready |=> !bus_rsp.rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("read response repeated");
endmodule
bind gpio_ports_abc gpio_ports_abc_sva u_sva (.clock, .reset_n, .bus_req, .bus_rsp, .a_pin_oe,
	.a_pullup_on, .b_pin_oe, .analog_channel_pins, .c_pin_oe, .c_pullup_on);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the three-port pin block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gpio_pkg::*;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	axil_req_t   req = '0;
	axil_rsp_t   rsp;
	logic [7:0]  pin = 8'h00;
	logic        can_tx = 1'b0;
	logic [7:0]  aout, aoe, apu, bout, boe, ana, kp;
	logic [6:0]  cout, coe, cpu;
	logic        crx;
	logic [23:0] oes, outs, pus;
	logic [31:0] got;
	logic [1:0]  resp;
	int          errors = 0;
	int          samples_checked = 0;
	assign oes = {1'b0, coe, boe, aoe};
	assign outs = {1'b0, cout, bout, aout};
	assign pus = {1'b0, cpu, 8'h00, apu};
	always #2.5 clock = ~clock;
	gpio_ports_abc DUT (.clock(clock), .reset_n(reset_n), .bus_req(req), .bus_rsp(rsp),
		.a_pin_in(pin), .a_pin_out(aout), .a_pin_oe(aoe), .a_pullup_on(apu),
		.b_pin_in(pin), .b_pin_out(bout), .b_pin_oe(boe), .analog_channel_pins(ana),
		.c_pin_in(pin[6:0]), .c_pin_out(cout), .c_pin_oe(coe), .c_pullup_on(cpu),
		.can_transmit_pin(can_tx), .can_receive_pin(crx), .keypad_inputs(kp));
	task automatic end_of_test();
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		@(posedge clock);
		req.awaddr <= {i, 2'h0};
		req.awvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end
		while (!rsp.bvalid);
		resp = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] i, input logic [31:0] e);
		@(posedge clock);
		req.araddr <= {i, 2'h0};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (rsp.arready) req.arvalid <= 1'b0;
		end
		while (!rsp.rvalid);
		got = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		chk(got, e);
	endtask
	task automatic t_reset();
		reset_n <= 1'b0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		chk({8'h00, oes}, 32'h0);
		chk({pus, ana}, 32'h0);
		for (int p = 0; p < 3; p++)
			rd(IDX_DIR_A + 6'(p), 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask
	task automatic t_port(input int p);
		logic [7:0] w;
		w = (p == 2) ? 8'h7F : 8'hFF;
		wr(IDX_LATCH_A + 6'(p), 8'hDA);
		pin <= 8'hC3;
		repeat (4) @(posedge clock);
		rd(IDX_LATCH_A + 6'(p), 32'(8'hC3 & w));
		chk(32'(oes[p*8 +: 8]), 32'h0);
		wr(IDX_DIR_A + 6'(p), 8'hF0);
		repeat (2) @(posedge clock);
		rd(IDX_DIR_A + 6'(p), 32'(8'hF0 & w));
		rd(IDX_LATCH_A + 6'(p), 32'(8'hD3 & w));
		chk(32'(oes[p*8 +: 8]), 32'(8'hF0 & w));
		chk(32'(outs[p*8 +: 8] & 8'hF0), 32'(8'hD0 & w));
		if (p != 1)
		begin
			wr(p == 0 ? IDX_PULL_A : IDX_PULL_C, 8'hFF);
			repeat (2) @(posedge clock);
			chk(32'(pus[p*8 +: 8]), 32'h0F);
		end
		chk({16'h0, pus[15:8], oes[15:8] & 8'h0F}, 32'h0);
		wr(IDX_LATCH_A + 6'(p), 8'hFF);
		rd(IDX_LATCH_A + 6'(p), 32'(8'hF3 & w));
		wr(IDX_LATCH_A + 6'(p), 8'hDA);
	endtask
	task automatic t_keep(input int p);
		wr(IDX_DIR_A + 6'(p), 8'hFF);
		rd(IDX_LATCH_A + 6'(p), 32'(8'hDA & ((p == 2) ? 8'h7F : 8'hFF)));
	endtask
	task automatic t_misc();
		rd(6'h3F, 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(6'h3F, 8'h55);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(IDX_ROUTE, 8'h0E);
		repeat (2) @(posedge clock);
		chk({16'h0, ana, boe}, 32'h08F7);
		wr(IDX_ROUTE, 8'h22);
		repeat (2) @(posedge clock);
		chk({16'h0, ana, boe}, 32'h00FF);
		wr(IDX_ROUTE, 8'h01);
		wr(IDX_DIR_C, 8'h00);
		can_tx <= 1'b1;
		pin <= 8'h00;
		repeat (4) @(posedge clock);
		chk({29'h0, coe[0], cout[0], crx}, 32'h6);
		wr(IDX_KEYPAD, 8'h3C);
		chk({30'h0, resp}, {30'h0, RESP_OKAY});
		pin <= 8'hFF;
		repeat (4) @(posedge clock);
		chk({24'h0, kp}, 32'h3C);
		chk({24'h0, aoe}, 32'hC3);
	endtask
	initial
	begin
		t_reset();
		for (int p = 0; p < 3; p++)
			t_port(p);
		t_reset();
		for (int p = 0; p < 3; p++)
			t_keep(p);
		t_misc();
		end_of_test();
	end
	// A stuck handshake would otherwise hang the run
	initial
	begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
